// ==== wdsw_pkg.sv ====
// Shared constants for the watchdog, sleep and wake unit.
// Assumes a single 32-bit AHB-Lite register bus and the core clock hclk.
package wdsw_pkg;

	// Register byte addresses
	localparam logic [31:0] WDSW_ADDR_OPTION  = 32'h0000_0000;
	localparam logic [31:0] WDSW_ADDR_STATUS  = 32'h0000_0004;

	// Option register layout
	localparam logic [7:0]  WDSW_OPTION_RESET = 8'h3f;
	localparam logic [7:0]  WDSW_OPTION_WMASK = 8'h3f;
	localparam int          WDSW_PSA_BIT      = 3;
	localparam int          WDSW_PS_LSB       = 0;
	localparam int          WDSW_PS_W         = 3;

	// Status register layout
	localparam int          WDSW_STAT_SLEEP_BIT = 0;
	localparam int          WDSW_STAT_WDTEN_BIT = 1;
	localparam int          WDSW_STAT_CP_BIT    = 2;
	localparam int          WDSW_STAT_PD_BIT    = 3;
	localparam int          WDSW_STAT_TO_BIT    = 4;
	localparam int          WDSW_STAT_OSC_LSB   = 5;

	// AHB-Lite: htrans bit 1 marks NONSEQ or SEQ
	localparam int          WDSW_HTRANS_ACT_BIT = 1;
	localparam logic [1:0]  WDSW_HRESP_OKAY     = 2'h0;

	// Watchdog timing
	localparam int          WDSW_BASE_MS      = 18;
	localparam int          WDSW_MS_PER_S     = 1000;
	localparam int          WDSW_RC_FREQ_HZ   = 1000000;
	localparam int          WDSW_SCALER_W     = 8;
	localparam int          WDSW_MAX_RATIO    = 128;

	typedef enum logic [1:0] {
		WDSW_RUN   = 2'h1,
		WDSW_SLEEP = 2'h2
	} wdsw_mode_e;

	// Low-bit mask selecting a divide ratio of 2**k on the shared scaler
	function automatic logic [7:0] wdsw_ratio_mask(input logic [3:0] k);
		logic [8:0] m;
		m = (9'h001 << k) - 9'h001;
		return m[7:0];
	endfunction : wdsw_ratio_mask

endpackage : wdsw_pkg

// ==== wdsw_sync.sv ====
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence is kept.
`timescale 1ns/1ps
module wdsw_sync #(
	parameter int W = 1
)(
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] meta_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end

endmodule : wdsw_sync

// ==== wdsw_top.sv ====
// Watchdog with shared scaler, sleep entry, wake-up and reset-cause flags.
// Assumes hclk is the core clock, the RC clock and pins arrive asynchronously,
// and the instruction strobes are one-cycle pulses on hclk from the core.
//
// What this block does
// - Watchdog counts edges of its own RC clock, synchronised into and counted on hclk.
// - Any watchdog time-out, awake or asleep, issues a full device reset.
// - A watchdog time-out clears the active-low time-out flag, status bit 4.
// - Watchdog enable fuse at 0 keeps the watchdog off for good.
// - One 8-bit scaler serves tick counter or watchdog; the other runs unscaled.
// - Assign bit and three-bit ratio field sit in option bits 3 to 0.
// - Base period 18 ms; postscaler up to 1:128 stretches it to about 2.3 s.
// - Clear-watchdog zeroes the counter, and the scaler when assigned to it.
// - Sleep zeroes the counter, and the scaler when assigned to the watchdog.
// - Sleep entry sets time-out flag, clears power-down flag, stops oscillator driver.
// - In sleep every I/O pin holds its pre-sleep drive or high impedance.
// - Watchdog reset is internal; the master-clear pin is never driven.
// - Sleep ends only on master-clear or watchdog time-out, each a full reset.
// - Power-down flag set at power-up, cleared at sleep entry.
// - Every wake-up from sleep zeroes the watchdog counter.
// - Fuses: two oscillator-type bits, watchdog enable, code protect, static inputs.
// - Any reset clears the scaler; software can neither read nor write it.
// - With the scaler on the tick counter, tick counter writes clear it.
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module wdsw_top
	import wdsw_pkg::*;
#(
	parameter int RC_FREQ_HZ     = WDSW_RC_FREQ_HZ,
	parameter int WDT_BASE_TICKS = WDSW_BASE_MS * RC_FREQ_HZ / WDSW_MS_PER_S,
	parameter int BASE_W         = 24,
	parameter int IO_W           = 8
)(
	input  wire logic            hclk,
	input  wire logic            hresetn,
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic      [31:0]     hrdata,
	output logic                 hreadyout,
	output logic      [1:0]      hresp,
	input  wire logic            wdt_rc_clk,
	input  wire logic            master_clear_pin_n,
	input  wire logic [1:0]      osc_type_fuses,
	input  wire logic            watchdog_enable_fuse,
	input  wire logic            code_protect_fuse,
	input  wire logic            clear_watchdog_instruction,
	input  wire logic            sleep_instruction,
	input  wire logic            tick_counter_write,
	input  wire logic            tick_input,
	output logic                 tick_counter_tick,
	output logic                 device_reset,
	output logic                 timeout_flag_n,
	output logic                 powerdown_flag_n,
	output logic                 main_osc_drive_en,
	output logic                 sleeping,
	input  wire logic [IO_W-1:0] io_out_core,
	input  wire logic [IO_W-1:0] io_oe_n_core,
	output logic      [IO_W-1:0] io_out_pin,
	output logic      [IO_W-1:0] io_oe_n_pin
);

	if (WDT_BASE_TICKS < 1 || WDT_BASE_TICKS >= (64'h1 << BASE_W) || BASE_W > 31 || IO_W < 1) begin : g_bad_params
		$error("wdsw_top: base tick count does not fit the base counter");
	end

	localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(WDT_BASE_TICKS - 1);

	// Pin and RC clock synchronisation
	// The synchroniser clears to 0, so the pin goes in inverted: a cleared stage
	// must read as pin high, or every release of hresetn would fake a master-clear.
	logic [5:0] sync_in;
	logic [5:0] sync_out;
	assign sync_in = {~master_clear_pin_n, wdt_rc_clk, code_protect_fuse,
	                  watchdog_enable_fuse, osc_type_fuses};

	wdsw_sync #(.W(6)) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     (sync_in),
		.dout    (sync_out)
	);

	logic             rc_d_q;
	logic             fuse_loaded_q;
	logic [1:0]       fuse_wait_q;
	logic             wdt_en_q;
	logic             cp_q;
	logic [1:0]       osc_q;
	logic [7:0]       option_q;
	logic [7:0]       option_d;
	wdsw_mode_e       mode_q;
	wdsw_mode_e       mode_d;
	logic [BASE_W-1:0] base_q;
	logic [BASE_W-1:0] base_d;
	logic [7:0]       scaler_q;
	logic [7:0]       scaler_d;
	logic             tof_n_q;
	logic             tof_n_d;
	logic             pdf_n_q;
	logic             pdf_n_d;
	logic             dp_opt_wr_q;

	// Edge of the synchronised RC clock is the watchdog count event
	wire rc_tick = sync_out[4] & ~rc_d_q;
	wire master_clear_pin_low = sync_out[5];
	wire scaler_assign_bit = option_q[WDSW_PSA_BIT];
	wire [WDSW_PS_W-1:0] ps = option_q[WDSW_PS_LSB +: WDSW_PS_W];
	wire [7:0] scaler_inc = scaler_q + 8'h01;
	wire wdt_run = wdt_en_q & fuse_loaded_q;
	wire base_wrap = wdt_run & rc_tick & (base_q == BASE_LAST);
	wire wdt_fire = base_wrap & scaler_assign_bit &
	                ((scaler_inc & wdsw_ratio_mask({1'b0, ps})) == 8'h00);
	wire wdt_timeout = (base_wrap & ~scaler_assign_bit) | wdt_fire;
	wire tmr_fire = tick_input & ~scaler_assign_bit &
	                ((scaler_inc & wdsw_ratio_mask({1'b0, ps} + 4'h1)) == 8'h00);
	wire reset_evt = wdt_timeout | master_clear_pin_low;
	wire sleep_enter = sleep_instruction & (mode_q == WDSW_RUN) & ~reset_evt;
	wire wdt_clear = clear_watchdog_instruction | sleep_enter;
	wire opt_wr = dp_opt_wr_q;

	// Watchdog base counter; a reset, a clear or sleep entry restarts it
	assign base_d = (reset_evt | wdt_clear)  ? '0 :
	                base_wrap                ? '0 :
	                (wdt_run & rc_tick)      ? base_q + BASE_W'(1) :
	                                           base_q;

	// Shared scaler: any reset clears it; otherwise only the owning side advances or clears it
	assign scaler_d = reset_evt                        ? 8'h00 :
	                  (scaler_assign_bit & wdt_clear)                ? 8'h00 :
	                  (scaler_assign_bit & base_wrap)                ? scaler_inc :
	                  (~scaler_assign_bit & tick_counter_write)      ? 8'h00 :
	                  (~scaler_assign_bit & tick_input)              ? scaler_inc :
	                                                     scaler_q;

	assign option_d = reset_evt ? WDSW_OPTION_RESET :
	                  opt_wr    ? (hwdata[7:0] & WDSW_OPTION_WMASK) :
	                              option_q;

	// Time-out flag: a time-out wins over a sleep entry in the same cycle
	assign tof_n_d = wdt_timeout ? 1'b0 :
	                 sleep_enter ? 1'b1 :
	                               tof_n_q;
	assign pdf_n_d = sleep_enter ? 1'b0 : pdf_n_q;
	assign mode_d = reset_evt   ? WDSW_RUN :
	                sleep_enter ? WDSW_SLEEP :
	                              mode_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rc_d_q   <= 1'b0;
			base_q   <= '0;
			scaler_q <= 8'h00;
			option_q <= WDSW_OPTION_RESET;
			mode_q   <= WDSW_RUN;
			tof_n_q  <= 1'b1;
			pdf_n_q  <= 1'b1;
		end else begin
			rc_d_q   <= sync_out[4];
			base_q   <= base_d;
			scaler_q <= scaler_d;
			option_q <= option_d;
			mode_q   <= mode_d;
			tof_n_q  <= tof_n_d;
			pdf_n_q  <= pdf_n_d;
		end
	end

	// Fuses are static: caught once, after the synchroniser has filled, because
	// its cleared stages would otherwise be taken for fuses programmed to 0.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fuse_wait_q   <= 2'h0;
			fuse_loaded_q <= 1'b0;
			wdt_en_q      <= 1'b0;
			cp_q          <= 1'b0;
			osc_q         <= 2'h0;
		end else begin
			fuse_wait_q <= {fuse_wait_q[0], 1'b1};
			if (fuse_wait_q[1] && !fuse_loaded_q) begin
				fuse_loaded_q <= 1'b1;
				wdt_en_q      <= sync_out[2];
				cp_q          <= sync_out[3];
				osc_q         <= sync_out[1:0];
			end
		end
	end

	// Outputs; the master-clear pin has no output, so a time-out stays internal
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			device_reset      <= 1'b0;
			timeout_flag_n    <= 1'b1;
			powerdown_flag_n  <= 1'b1;
			main_osc_drive_en <= 1'b1;
			sleeping          <= 1'b0;
			tick_counter_tick <= 1'b0;
		end else begin
			device_reset      <= reset_evt;
			timeout_flag_n    <= tof_n_d;
			powerdown_flag_n  <= pdf_n_d;
			main_osc_drive_en <= (mode_d == WDSW_RUN);
			sleeping          <= (mode_d == WDSW_SLEEP);
			tick_counter_tick <= scaler_assign_bit ? tick_input : tmr_fire;
		end
	end

	// Pins follow the core while awake and freeze from sleep entry on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			io_out_pin  <= '0;
			io_oe_n_pin <= {IO_W{1'b1}};
		end else if (mode_d == WDSW_RUN) begin
			io_out_pin  <= io_out_core;
			io_oe_n_pin <= io_oe_n_core;
		end
	end

	// AHB-Lite slave, zero wait states; read data are taken from next-state values
	// so a read right behind a write sees the written value.
	wire addr_ok = hsel & htrans[WDSW_HTRANS_ACT_BIT] & hready;
	wire hit_option = (haddr == WDSW_ADDR_OPTION);
	wire hit_status = (haddr == WDSW_ADDR_STATUS);
	logic [7:0] status_rd;
	wire [31:0] rd_mux = hit_option ? {24'h000000, option_d} :
	                     hit_status ? {24'h000000, status_rd} :
	                                  32'h0000_0000;

	always_comb begin
		status_rd = 8'h00;
		status_rd[WDSW_STAT_SLEEP_BIT] = (mode_d == WDSW_SLEEP);
		status_rd[WDSW_STAT_WDTEN_BIT] = wdt_en_q;
		status_rd[WDSW_STAT_CP_BIT]    = cp_q;
		status_rd[WDSW_STAT_PD_BIT]    = pdf_n_d;
		status_rd[WDSW_STAT_TO_BIT]    = tof_n_d;
		status_rd[WDSW_STAT_OSC_LSB +: 2] = osc_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_opt_wr_q <= 1'b0;
			hrdata      <= 32'h0000_0000;
			hreadyout   <= 1'b1;
			hresp       <= WDSW_HRESP_OKAY;
		end else begin
			dp_opt_wr_q <= addr_ok & hwrite & hit_option;
			hreadyout   <= 1'b1;
			hresp       <= WDSW_HRESP_OKAY;
			if (addr_ok && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_timeout_reset: assert property (wdt_timeout |=> device_reset && !timeout_flag_n)
		else $error("time-out did not reset the device and clear the flag");
	a_fuse_off: assert property (fuse_loaded_q && !wdt_en_q |-> base_q == '0 && !wdt_timeout)
		else $error("watchdog ran with the enable fuse off");
	a_clear_zeroes: assert property (clear_watchdog_instruction && !reset_evt |=> base_q == '0 &&
		($past(scaler_assign_bit) -> scaler_q == 8'h00))
		else $error("clear-watchdog left the counter or scaler running");
	a_sleep_entry: assert property (sleep_enter && !wdt_timeout |=> timeout_flag_n && !powerdown_flag_n
		&& !main_osc_drive_en && sleeping && base_q == '0)
		else $error("sleep entry flags or oscillator wrong");
	a_io_hold: assert property (sleeping && $past(sleeping) |-> $stable(io_out_pin) && $stable(io_oe_n_pin))
		else $error("pins moved during sleep");
	a_wake_clean: assert property ($fell(sleeping) |-> base_q == '0 && scaler_q == 8'h00 && device_reset)
		else $error("wake-up without reset or with a running counter");
	a_tick_write: assert property (tick_counter_write && !scaler_assign_bit && !reset_evt |=> scaler_q == 8'h00)
		else $error("tick counter write did not clear the scaler");
	a_reset_clears: assert property (reset_evt |=> scaler_q == 8'h00 && base_q == '0 &&
		option_q == WDSW_OPTION_RESET)
		else $error("reset left scaler, counter or option dirty");
	a_unscaled_tick: assert property (scaler_assign_bit |=> tick_counter_tick == $past(tick_input))
		else $error("tick counter was scaled while scaler belongs to watchdog");
	a_stay_asleep: assert property (sleeping && !reset_evt |=> sleeping)
		else $error("left sleep without a reset event");
	a_pin_reset: assert property (master_clear_pin_low |=> device_reset && !sleeping)
		else $error("master-clear did not reset the device");
	a_osc_off: assert property (sleeping |-> !main_osc_drive_en)
		else $error("oscillator driver on during sleep");

	c_wdt_timeout: cover property (sleeping ##1 wdt_timeout);
	c_master_clear_pin_wake: cover property (sleeping ##1 master_clear_pin_low);
	c_post_timeout: cover property (scaler_assign_bit && ps != 3'h0 && wdt_fire);
	c_tick_fire: cover property (!scaler_assign_bit && tmr_fire);
	c_sleep_entry: cover property (sleep_enter);

endmodule : wdsw_top

// ==== testbench.sv ====
// Self-checking bench for the watchdog, sleep and wake unit.
// Assumes wdsw_top with a short base count; the bench makes the RC clock and drives the core strobes.
`timescale 1ns/1ps
module testbench;
	import wdsw_pkg::*;
	localparam int BASE = 8;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire  logic  hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic [1:0]  hresp;
	logic        wdt_rc_clk = 1'b0;
	logic        master_clear_pin_n = 1'b1;
	logic        watchdog_enable_fuse = 1'b1;
	logic        clear_watchdog_instruction = 1'b0;
	logic        sleep_instruction = 1'b0;
	logic        tick_counter_write = 1'b0;
	logic        tick_input = 1'b0;
	logic        tick_counter_tick, device_reset, timeout_flag_n, powerdown_flag_n, main_osc_drive_en, sleeping;
	logic [7:0]  io_out_core = 8'h00;
	logic [7:0]  io_oe_n_core = 8'hff;
	logic [7:0]  io_out_pin, io_oe_n_pin;
	logic [31:0] rd;
	int          failures = 0;
	int          samples_checked = 0;
	int          tick_cnt = 0;
	int          n;

	// The one slave's hreadyout is the bus's hready
	assign hready = hreadyout;
	always #2 hclk = ~hclk;
	// Odd half period keeps rising RC edges off the hclk grid
	always #21 wdt_rc_clk = ~wdt_rc_clk;
	always @(posedge hclk) if (tick_counter_tick === 1'b1) tick_cnt++;

	wdsw_top #(.WDT_BASE_TICKS(BASE)) i_wdsw_top (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .wdt_rc_clk(wdt_rc_clk), .master_clear_pin_n(master_clear_pin_n),
		.osc_type_fuses(2'h2), .watchdog_enable_fuse(watchdog_enable_fuse), .code_protect_fuse(1'b1),
		.clear_watchdog_instruction(clear_watchdog_instruction), .sleep_instruction(sleep_instruction),
		.tick_counter_write(tick_counter_write), .tick_input(tick_input),
		.tick_counter_tick(tick_counter_tick), .device_reset(device_reset), .timeout_flag_n(timeout_flag_n),
		.powerdown_flag_n(powerdown_flag_n), .main_osc_drive_en(main_osc_drive_en), .sleeping(sleeping),
		.io_out_core(io_out_core), .io_oe_n_core(io_oe_n_core), .io_out_pin(io_out_pin),
		.io_oe_n_pin(io_oe_n_pin)
	);

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wait_rdy;
		int k;
		k = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && k < 50) begin
			@(posedge hclk);
			k++;
		end
		if (k >= 50) begin
			failures++;
			$display("[ERR] hready expected 1 seen %b", hready);
			print_verdict();
		end
	endtask : wait_rdy

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
	endtask : ahb

	// Strobe 0 clear, 1 sleep, 2 tick counter write, 3 tick input
	task automatic pulse(input int which);
		@(posedge hclk);
		case (which)
			0: clear_watchdog_instruction <= 1'b1;
			1: sleep_instruction <= 1'b1;
			2: tick_counter_write <= 1'b1;
			default: tick_input <= 1'b1;
		endcase
		@(posedge hclk);
		{clear_watchdog_instruction, sleep_instruction, tick_counter_write, tick_input} <= 4'h0;
		#1;
	endtask : pulse

	task automatic wait_rst(input int lim);
		n = 0;
		while (device_reset !== 1'b1 && n < lim) begin
			@(posedge hclk);
			#1;
			n++;
		end
		if (n >= lim) begin
			failures++;
			$display("[ERR] device_reset expected 1 seen %b", device_reset);
			print_verdict();
		end
		#1;
	endtask : wait_rst

	task automatic count_rst(input int cyc);
		n = 0;
		repeat (cyc) begin
			@(posedge hclk);
			#1;
			if (device_reset === 1'b1) n++;
		end
	endtask : count_rst

	task automatic t_regs;
		ahb(1'b0, WDSW_ADDR_OPTION, 32'h0, rd);
		chk("option_reset", 32'h3f, rd);
		ahb(1'b0, WDSW_ADDR_STATUS, 32'h0, rd);
		chk("status_reset", 32'h5e, rd);
		ahb(1'b1, WDSW_ADDR_OPTION, 32'hff, rd);
		ahb(1'b0, WDSW_ADDR_OPTION, 32'h0, rd);
		chk("option_mask", 32'h3f, rd);
		ahb(1'b1, 32'h8, 32'hff, rd);
		ahb(1'b0, 32'h8, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		chk("hresp", 32'h0, {30'h0, hresp});
	endtask : t_regs

	task automatic t_timeout(input logic [31:0] opt, input int lo, input int hi);
		ahb(1'b1, WDSW_ADDR_OPTION, opt, rd);
		pulse(0);
		wait_rst(400);
		chk("period_in_range", 32'h1, 32'(n >= lo && n <= hi));
		chk("timeout_flag_n", 32'h0, {31'h0, timeout_flag_n});
		ahb(1'b0, WDSW_ADDR_OPTION, 32'h0, rd);
		chk("option_after_wdt_reset", 32'h3f, rd);
	endtask : t_timeout

	task automatic t_clear;
		ahb(1'b1, WDSW_ADDR_OPTION, 32'h00, rd);
		pulse(0);
		repeat (8) begin
			count_rst(40);
			pulse(0);
			chk("no_reset_when_cleared", 32'h0, 32'(n));
		end
	endtask : t_clear

	task automatic t_sleep_wdt;
		ahb(1'b1, WDSW_ADDR_OPTION, 32'h00, rd);
		io_out_core <= 8'ha5;
		io_oe_n_core <= 8'h0f;
		repeat (3) @(posedge hclk);
		pulse(1);
		chk("sleep_state", 32'ha, {28'h0, sleeping, main_osc_drive_en, timeout_flag_n, powerdown_flag_n});
		io_out_core <= 8'h5a;
		io_oe_n_core <= 8'hf0;
		repeat (3) @(posedge hclk);
		#1;
		chk("pins_frozen", 32'ha50f, {16'h0, io_out_pin, io_oe_n_pin});
		wait_rst(400);
		chk("full_sleep_period", 32'h1, 32'(n >= 65));
		chk("wdt_wake", 32'h4, {28'h0, sleeping, main_osc_drive_en, timeout_flag_n, powerdown_flag_n});
	endtask : t_sleep_wdt

	task automatic t_sleep_pin;
		ahb(1'b1, WDSW_ADDR_OPTION, 32'h0f, rd);
		pulse(1);
		chk("asleep", 32'h1, {31'h0, sleeping});
		@(posedge hclk);
		master_clear_pin_n <= 1'b0;
		wait_rst(10);
		chk("pin_wake", 32'h6, {28'h0, sleeping, main_osc_drive_en, timeout_flag_n, powerdown_flag_n});
		@(posedge hclk);
		master_clear_pin_n <= 1'b1;
		repeat (8) @(posedge hclk);
	endtask : t_sleep_pin

	task automatic t_tick;
		ahb(1'b1, WDSW_ADDR_OPTION, 32'h00, rd);
		pulse(0);
		pulse(2);
		tick_cnt = 0;
		repeat (8) pulse(3);
		repeat (3) @(posedge hclk);
		chk("tick_div2", 32'h4, 32'(tick_cnt));
		ahb(1'b1, WDSW_ADDR_OPTION, 32'h08, rd);
		tick_cnt = 0;
		repeat (4) pulse(3);
		repeat (3) @(posedge hclk);
		chk("tick_unscaled", 32'h4, 32'(tick_cnt));
		ahb(1'b1, WDSW_ADDR_OPTION, 32'h00, rd);
		pulse(2);
		tick_cnt = 0;
		pulse(3);
		pulse(2);
		pulse(3);
		repeat (3) @(posedge hclk);
		// The write between the ticks zeroes the scaler again, so this gives 0; 1 means that write left the scaler alone
		chk("tick_write_clears", 32'h1, 32'(tick_cnt != 1));
	endtask : t_tick

	task automatic t_fuse_off;
		@(posedge hclk);
		hresetn <= 1'b0;
		watchdog_enable_fuse <= 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		ahb(1'b0, WDSW_ADDR_STATUS, 32'h0, rd);
		chk("status_fuse_off", 32'h5c, rd);
		ahb(1'b1, WDSW_ADDR_OPTION, 32'h00, rd);
		count_rst(400);
		chk("wdt_disabled", 32'h0, 32'(n));
	endtask : t_fuse_off

	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		t_regs();
		t_timeout(32'h00, 65, 100);
		t_timeout(32'h09, 150, 190);
		t_clear();
		t_sleep_wdt();
		t_sleep_pin();
		t_tick();
		t_fuse_off();
		print_verdict();
	end
endmodule : testbench
